// file: logic/tzp_defs.svh
// Purpose: named offsets, field positions, reset values and counts of the timer block
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef TZP_DEFS_SVH
`define TZP_DEFS_SVH

// register offsets, bank-select bit is address bit 7
`define TZP_ADR_TMR      8'h01
`define TZP_ADR_INT_B0   8'h0B
`define TZP_ADR_INT_B1   8'h8B
`define TZP_ADR_OPT      8'h81
`define TZP_ADR_TRA      8'h85

// reset values
`define TZP_RST_TMR      8'h00
`define TZP_RST_INT      8'h00
`define TZP_RST_OPT      8'hFF
`define TZP_RST_TRA      5'h1F

// interrupt_control fields
`define TZP_INT_GLB_EN   7
`define TZP_INT_TIE      5
`define TZP_INT_TIF      2
`define TZP_INT_MASK     8'hBF

// option_config fields
`define TZP_OPT_CS       5
`define TZP_OPT_SE       4
`define TZP_OPT_ASSIGN   3
`define TZP_OPT_PS_HI    2

// port_a_direction width
`define TZP_TRA_W        5
`define TZP_TRA_PAD      3'h0

// counts
`define TZP_WR_INHIBIT   2'h2
`define TZP_TMR_MAX      8'hFF
`define TZP_WDT_BASE_MAX 8'hFF
`define TZP_ZERO8        8'h00

`endif

// file: logic/tzp_pkg.sv
// Purpose: shared types of the timer block
// Assumes: nothing
// Notes:   constants live in tzp_defs.svh
package tzp_pkg;
  typedef logic [7:0] tzp_byte_t;
  typedef logic [2:0] tzp_ratio_t;
  typedef enum logic {TZP_OWN_TIMER, TZP_OWN_WDT} tzp_owner_t;
endpackage : tzp_pkg

// file: logic/tzp_prescaler.sv
// Purpose: 8-bit scaler counter shared by timer and watchdog
// Assumes: tick_in is a one-cycle enable
// Notes:   not readable or writable by software
`timescale 1ns/10ps
`include "tzp_defs.svh"
module tzp_prescaler (
  input  wire logic   i_clk,
  input  wire logic   i_srst,
  tzp_scaler_if.scaler sif
);
  import tzp_pkg::*;

  logic [7:0] cnt_r;
  logic [7:0] mask;

  // timer divides by 2^(ratio+1), watchdog by 2^ratio
  function automatic logic [7:0] div_mask(input tzp_ratio_t r, input tzp_owner_t o);
    logic [3:0] n;
    n = {1'b0, r} + ((o == TZP_OWN_TIMER) ? 4'h1 : 4'h0);
    div_mask = 8'((9'h001 << n) - 9'h001);
  endfunction : div_mask

  assign mask         = div_mask(sif.ratio, sif.owner);
  assign sif.tick_out = sif.tick_in && ((cnt_r & mask) == mask);

  // clear wins over a tick in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_r <= `TZP_ZERO8;
    end else if (sif.clear) begin
      cnt_r <= `TZP_ZERO8;
    end else if (sif.tick_in) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_scaler_clear: assert property (@(posedge i_clk) disable iff (i_srst)
    sif.clear |=> (cnt_r == `TZP_ZERO8))
    else $error("scaler not cleared");
  chk_wdt_div_one: assert property (@(posedge i_clk) disable iff (i_srst)
    (sif.owner == TZP_OWN_WDT && sif.ratio == 3'h0 && sif.tick_in) |-> sif.tick_out)
    else $error("watchdog ratio zero must pass every tick");
  chk_tmr_div_256: assert property (@(posedge i_clk) disable iff (i_srst)
    (sif.owner == TZP_OWN_TIMER && sif.ratio == 3'h7 && sif.tick_in && sif.tick_out)
    |-> (cnt_r == 8'hFF))
    else $error("timer ratio seven must divide by 256");
endmodule : tzp_prescaler

// file: logic/tzp_scaler_if.sv
// Purpose: link between timer core and shared scaler counter
// Assumes: one clock domain
// Notes:   tick_out is combinational from the scaler state
`timescale 1ns/10ps
interface tzp_scaler_if;
  logic                   tick_in;
  logic                   clear;
  tzp_pkg::tzp_ratio_t    ratio;
  tzp_pkg::tzp_owner_t    owner;
  logic                   tick_out;
  modport host   (output tick_in, output clear, output ratio, output owner, input tick_out);
  modport scaler (input tick_in, input clear, input ratio, input owner, output tick_out);
endinterface : tzp_scaler_if

// file: logic/tzp_timer0.sv
// Purpose: 8-bit timer/counter with scaler shared with the watchdog
// Assumes: one I_SYS_CLK cycle is one instruction cycle; inputs synchronous
// Notes:   watchdog advances only on the RC oscillator tick input
//
// Contract
// - watchdog clear resets watchdog counter and shared scaler counter
// - writing timer_count clears the scaler while it is assigned to the timer
// - unimplemented register bits always read as zero
// - watchdog and its scaler are clocked from the dedicated RC oscillator tick
// - internal source counts each cycle; two cycles inhibited after a count write
// - external source counts input edges; edge select zero rising, one falling
// - rollover FFh to 00h sets flag; interrupt only when enabled; software clears
// - assign bit zero gives scaler to timer, one gives it to the watchdog
`timescale 1ns/10ps
`include "tzp_defs.svh"
module tzp_timer0 (
  input  wire logic             I_SYS_CLK,
  input  wire logic             I_SRST,
  input  wire tzp_pkg::tzp_byte_t I_ADDR,
  input  wire tzp_pkg::tzp_byte_t I_WDATA,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  input  wire logic             I_WDT_CLR,
  input  wire logic             I_WDT_ENABLE,
  input  wire logic             I_WDT_OSC_TICK,
  input  wire logic             I_EXT_COUNT_INPUT,
  output tzp_pkg::tzp_byte_t    O_RDATA,
  output logic                  O_IRQ,
  output logic                  O_WDT_TIMEOUT,
  output logic [4:0]            O_PORTA_DIR
);
  import tzp_pkg::*;

  tzp_scaler_if sif ();

  tzp_byte_t  timer_r;
  tzp_byte_t  irq_ctrl_r;
  tzp_byte_t  option_r;
  logic [4:0] dir_r;
  logic [1:0] inhibit_r;
  logic       ext_prev_r;
  tzp_byte_t  wdt_cnt_r;
  tzp_byte_t  rdata_r;
  logic       irq_r;
  logic       timeout_r;

  logic       wr_tmr, wr_int, wr_opt, wr_tra;
  logic       ext_edge, src_tick, tmr_tick, tmr_inc, tif_set;
  logic       wdt_base_ovf, wdt_timeout;
  tzp_owner_t owner;
  tzp_byte_t  rd_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // decode and count sources
  assign wr_tmr   = I_WR && (I_ADDR == `TZP_ADR_TMR);
  assign wr_int   = I_WR && ((I_ADDR == `TZP_ADR_INT_B0) || (I_ADDR == `TZP_ADR_INT_B1));
  assign wr_opt   = I_WR && (I_ADDR == `TZP_ADR_OPT);
  assign wr_tra   = I_WR && (I_ADDR == `TZP_ADR_TRA);
  assign ext_edge = option_r[`TZP_OPT_SE] ? (ext_prev_r && !I_EXT_COUNT_INPUT)
                                          : (!ext_prev_r && I_EXT_COUNT_INPUT);
  assign src_tick = option_r[`TZP_OPT_CS] ? ext_edge : 1'b1;
  assign owner    = option_r[`TZP_OPT_ASSIGN] ? TZP_OWN_WDT : TZP_OWN_TIMER;

  // watchdog base count steps only on RC oscillator ticks
  assign wdt_base_ovf = I_WDT_ENABLE && I_WDT_OSC_TICK && !I_WDT_CLR
                        && (wdt_cnt_r == `TZP_WDT_BASE_MAX);

  assign sif.owner   = owner;
  assign sif.ratio   = option_r[`TZP_OPT_PS_HI:0];
  assign sif.tick_in = (owner == TZP_OWN_TIMER) ? src_tick : wdt_base_ovf;
  // clear works even with the watchdog disabled, so the switch sequence is safe
  assign sif.clear   = I_WDT_CLR
                       || (wr_tmr && (owner == TZP_OWN_TIMER));

  assign tmr_tick    = (owner == TZP_OWN_TIMER) ? sif.tick_out : src_tick;
  assign tmr_inc     = tmr_tick && (inhibit_r == 2'h0) && !wr_tmr;
  assign tif_set     = tmr_inc && (timer_r == `TZP_TMR_MAX);
  assign wdt_timeout = (owner == TZP_OWN_WDT) ? sif.tick_out : wdt_base_ovf;

  tzp_prescaler u_scaler (
    .i_clk  (I_SYS_CLK),
    .i_srst (I_SRST),
    .sif    (sif.scaler)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // timer count and write inhibit
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      timer_r <= `TZP_RST_TMR;
    end else if (wr_tmr) begin
      timer_r <= I_WDATA;
    end else if (tmr_inc) begin
      timer_r <= timer_r + 8'h01;
    end
  end

  // adjusted write values are the user's workaround for the two lost counts
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      inhibit_r <= 2'h0;
    end else if (wr_tmr) begin
      inhibit_r <= `TZP_WR_INHIBIT;
    end else if (inhibit_r != 2'h0) begin
      inhibit_r <= inhibit_r - 2'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= I_EXT_COUNT_INPUT;
    end
  end

  // interrupt_control: overflow set wins over a software clear
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      irq_ctrl_r <= `TZP_RST_INT;
    end else begin
      if (wr_int) begin
        irq_ctrl_r <= I_WDATA & `TZP_INT_MASK;
      end
      if (tif_set) begin
        irq_ctrl_r[`TZP_INT_TIF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      option_r <= `TZP_RST_OPT;
      dir_r    <= `TZP_RST_TRA;
    end else begin
      if (wr_opt) begin
        option_r <= I_WDATA;
      end
      if (wr_tra) begin
        dir_r <= I_WDATA[`TZP_TRA_W-1:0];
      end
    end
  end

  // watchdog base counter
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST || I_WDT_CLR) begin
      wdt_cnt_r <= `TZP_ZERO8;
    end else if (I_WDT_ENABLE && I_WDT_OSC_TICK) begin
      wdt_cnt_r <= wdt_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port and outputs
  always_comb begin
    case (I_ADDR)
      `TZP_ADR_TMR:    rd_nxt = timer_r;
      `TZP_ADR_INT_B0: rd_nxt = irq_ctrl_r & `TZP_INT_MASK;
      `TZP_ADR_INT_B1: rd_nxt = irq_ctrl_r & `TZP_INT_MASK;
      `TZP_ADR_OPT:    rd_nxt = option_r;
      `TZP_ADR_TRA:    rd_nxt = {`TZP_TRA_PAD, dir_r};
      default:         rd_nxt = `TZP_ZERO8;
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      rdata_r   <= `TZP_ZERO8;
      irq_r     <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      if (I_RD) begin
        rdata_r <= rd_nxt;
      end
      irq_r     <= irq_ctrl_r[`TZP_INT_GLB_EN] && irq_ctrl_r[`TZP_INT_TIE]
                   && irq_ctrl_r[`TZP_INT_TIF];
      timeout_r <= wdt_timeout;
    end
  end

  assign O_RDATA       = rdata_r;
  assign O_IRQ         = irq_r;
  assign O_WDT_TIMEOUT = timeout_r;
  assign O_PORTA_DIR   = dir_r;

  ////////////////////////////////////////////////////////////////////////////////
  chk_write_scaler_clr: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (wr_tmr && !option_r[`TZP_OPT_ASSIGN]) |-> sif.clear)
    else $error("count write did not clear scaler");
  chk_write_inhibit: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (wr_tmr ##1 !wr_tmr ##1 !wr_tmr) |=> (timer_r == $past(I_WDATA, 3)))
    else $error("count moved inside two-cycle inhibit");
  chk_internal_step: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (!option_r[`TZP_OPT_CS] && option_r[`TZP_OPT_ASSIGN] && inhibit_r == 2'h0 && !wr_tmr)
    |=> (timer_r == $past(timer_r) + 8'h01))
    else $error("internal source missed a cycle");
  chk_ext_edge: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (option_r[`TZP_OPT_CS] && option_r[`TZP_OPT_ASSIGN] && !wr_tmr && !I_EXT_COUNT_INPUT
     && ext_prev_r == !option_r[`TZP_OPT_SE]) |=> $stable(timer_r))
    else $error("count moved without the selected edge");
  chk_ovf_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (tmr_inc && timer_r == `TZP_TMR_MAX) |=> (timer_r == 8'h00 && irq_ctrl_r[`TZP_INT_TIF]))
    else $error("rollover did not set overflow flag");
  chk_irq_gate: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    !irq_ctrl_r[`TZP_INT_TIE] |=> !O_IRQ)
    else $error("interrupt raised while disabled");
  chk_unimpl_zero: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (I_RD && (I_ADDR == `TZP_ADR_TRA || I_ADDR == `TZP_ADR_INT_B0))
    |=> ((($past(I_ADDR) == `TZP_ADR_TRA) ? O_RDATA[7:5] : {2'h0, O_RDATA[6]}) == 3'h0))
    else $error("unimplemented bit read as one");
  chk_wdt_rc_only: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (!I_WDT_OSC_TICK && !I_WDT_CLR) |=> $stable(wdt_cnt_r))
    else $error("watchdog moved without oscillator tick");
  chk_wdt_clear: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    I_WDT_CLR |=> (wdt_cnt_r == `TZP_ZERO8))
    else $error("watchdog clear missed");
  chk_assign_route: assert property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    (option_r[`TZP_OPT_ASSIGN] && !wdt_base_ovf) |-> !sif.tick_in)
    else $error("scaler fed by timer while assigned to watchdog");

  cov_overflow:  cover property (@(posedge I_SYS_CLK) disable iff (I_SRST) tif_set);
  cov_timeout:   cover property (@(posedge I_SYS_CLK) disable iff (I_SRST) O_WDT_TIMEOUT);
  cov_ext_count: cover property (@(posedge I_SYS_CLK) disable iff (I_SRST)
    option_r[`TZP_OPT_CS] && tmr_inc);
  cov_irq:       cover property (@(posedge I_SYS_CLK) disable iff (I_SRST) O_IRQ);
endmodule : tzp_timer0

// file: verification/tzp_timer0_tb.sv
// Purpose: self-checking bench of the shared-scaler timer block
// Assumes: bench drives every port at the falling clock edge; no partner model
// Notes:   reset values first, then register rows, then hand-written timer, scaler and watchdog cases
`timescale 1ns/10ps
`include "tzp_defs.svh"
module testbench;
  import tzp_pkg::*;
  localparam tzp_byte_t tmr_a = `TZP_ADR_TMR;
  localparam tzp_byte_t int_a = `TZP_ADR_INT_B0;
  localparam tzp_byte_t opt_a = `TZP_ADR_OPT;
  logic        clk        = 1'b0;
  logic        srst       = 1'b1;
  tzp_byte_t   addr       = 8'h00;
  tzp_byte_t   wdata      = 8'h00;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        wclr       = 1'b0;
  logic        wen        = 1'b0;
  logic        wtick      = 1'b0;
  logic        ext        = 1'b0;
  tzp_byte_t   rdata;
  logic        irq;
  logic        wto;
  logic [4:0]  pdir;
  tzp_byte_t   got;
  int          bad_count  = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  int          to_cnt     = 0;
  // write address, write data, read address, expected read
  logic [31:0] rows [7]   = '{32'h85FF_851F, 32'h850A_850A, 32'h8B5B_0B1B, 32'h0B00_8B00,
                              32'h813F_813F, 32'h015A_015A, 32'h5577_7700};
  logic [15:0] rst_rows [4] = '{16'h81FF, 16'h0B00, 16'h851F, 16'h0100};
  tzp_byte_t   pre_opt [4] = '{8'h20, 8'h21, 8'h22, 8'h28};
  tzp_byte_t   pre_exp [4] = '{8'h04, 8'h02, 8'h01, 8'h08};

  tzp_timer0 dut (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_WDT_CLR(wclr), .I_WDT_ENABLE(wen), .I_WDT_OSC_TICK(wtick), .I_EXT_COUNT_INPUT(ext),
    .O_RDATA(rdata), .O_IRQ(irq), .O_WDT_TIMEOUT(wto), .O_PORTA_DIR(pdir));

  ////////////////////////////////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;

  // hang guard: run needs about 2300 cycles
  always @(posedge clk) begin
    cycles++;
    if (wto === 1'b1) to_cnt++;
    if (cycles == 6000) begin
      bad_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string nm, input tzp_byte_t e, input tzp_byte_t a);
    n_compared++;
    if (a !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, a);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic a);
    n_compared++;
    if (a !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, a);
    end
  endtask : chk1

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // extra cycle at the end so a strobe never drops and rises in one step
  task automatic wr_reg(input tzp_byte_t a, input tzp_byte_t d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg

  task automatic rd_reg(input tzp_byte_t a);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    got = rdata;
    @(negedge clk);
  endtask : rd_reg

  // four cycles per level, well past the edge detect latency
  task automatic ext_set(input logic v);
    ext = v;
    idle(4);
  endtask : ext_set

  task automatic ext_pulse();
    ext_set(1'b1);
    ext_set(1'b0);
  endtask : ext_pulse

  task automatic clr_pulse();
    wclr = 1'b1;
    @(negedge clk);
    wclr = 1'b0;
    @(negedge clk);
  endtask : clr_pulse

  task automatic wdt_ticks(input int n);
    repeat (n) begin
      wtick = 1'b1;
      @(negedge clk);
      wtick = 1'b0;
      @(negedge clk);
    end
  endtask : wdt_ticks

  task automatic rst_chk();
    foreach (rst_rows[i]) begin
      rd_reg(rst_rows[i][15:8]);
      chk8("reset value", rst_rows[i][7:0], got);
    end
    chk8("port dir", 8'h1F, {3'h0, pdir});
    chk1("irq", 1'b0, irq);
  endtask : rst_chk

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(4);
    srst = 1'b0;
    rst_chk();
    foreach (rows[i]) begin
      wr_reg(rows[i][31:24], rows[i][23:16]);
      rd_reg(rows[i][15:8]);
      chk8("row read", rows[i][7:0], got);
    end
    chk8("port dir", 8'h0A, {3'h0, pdir});
    // internal source, write inhibit and rollover
    wr_reg(int_a, 8'hA0);
    wr_reg(opt_a, 8'h08);
    for (int k = 2; k < 7; k++) begin
      wr_reg(tmr_a, 8'hFE);
      idle(k - 2);
      rd_reg(tmr_a);
      chk8("timer", tzp_byte_t'((k < 4) ? 254 : 251 + k), got);
    end
    chk1("irq", 1'b1, irq);
    rd_reg(int_a);
    chk8("flag", 8'hA4, got);
    wr_reg(int_a, 8'h84);
    chk1("irq masked", 1'b0, irq);
    wr_reg(int_a, 8'hA0);
    rd_reg(int_a);
    chk8("flag clear", 8'hA0, got);
    // external edges, rising then falling select
    wr_reg(opt_a, 8'h28);
    wr_reg(tmr_a, 8'h00);
    idle(1);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wr_reg(opt_a, 8'h38);
      ext_set(~i[0]);
      rd_reg(tmr_a);
      chk8("ext count", (i == 3) ? 8'h02 : 8'h01, got);
    end
    // scaler ratios, moved with the safe software order
    foreach (pre_opt[r]) begin
      clr_pulse();
      wr_reg(tmr_a, 8'h00);
      if (pre_opt[r][3]) begin
        wr_reg(opt_a, 8'h2F);
        clr_pulse();
      end
      wr_reg(opt_a, pre_opt[r]);
      repeat (8) ext_pulse();
      rd_reg(tmr_a);
      chk8("scaled count", pre_exp[r], got);
    end
    // scaler cleared by count write and by watchdog clear
    clr_pulse();
    wr_reg(opt_a, 8'h20);
    wr_reg(tmr_a, 8'h00);
    ext_pulse();
    wr_reg(tmr_a, 8'h00);
    idle(1);
    ext_pulse();
    rd_reg(tmr_a);
    chk8("count write clear", 8'h00, got);
    clr_pulse();
    ext_pulse();
    rd_reg(tmr_a);
    chk8("wdt clear scaler", 8'h00, got);
    ext_pulse();
    rd_reg(tmr_a);
    chk8("scaled step", 8'h01, got);
    // watchdog on its own tick, ratio 1:1
    clr_pulse();
    wr_reg(tmr_a, 8'h00);
    wr_reg(opt_a, 8'h2F);
    clr_pulse();
    wr_reg(opt_a, 8'h28);
    idle(300);
    wdt_ticks(300);
    chk8("timeouts off", 8'h00, tzp_byte_t'(to_cnt));
    wen = 1'b1;
    clr_pulse();
    wdt_ticks(200);
    clr_pulse();
    wdt_ticks(255);
    idle(3);
    chk8("timeouts early", 8'h00, tzp_byte_t'(to_cnt));
    wdt_ticks(1);
    idle(3);
    chk8("timeouts", 8'h01, tzp_byte_t'(to_cnt));
    // second reset in mid-run
    wr_reg(int_a, 8'hA4);
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    rst_chk();
    stop_test();
  end
endmodule : testbench
